// *** rtl/iig_glue.v ***
// IDE interface glue: data bit 7 steering, byte latch enables, and the shared DMA-acknowledge/strap pin.
// Assumes host strobes and drive pins come from outside the clock domain and are synchronised here.
`timescale 1ns/100ps
`include "iig_map.vh"

module iig_glue (
    input  wire                    CLK,
    input  wire                    ARST_N,
    input  wire [`IIG_ADDR_W-1:0]  ADDR,
    input  wire                    IOR_N,
    input  wire                    IOW_N,
    input  wire                    AEN,
    input  wire                    HOST_D7_IN,
    input  wire                    IDE_D7_IN,
    input  wire                    IOCS16_N,
    input  wire                    SHARED_PIN,
    input  wire                    FUNC_DMA_SEL,
    input  wire                    IDE_ENABLE,
    input  wire                    USE_SECONDARY,
    input  wire                    HIGH_RATE,
    output reg                     IDE_D7_OUT,
    output reg                     IDE_D7_OE,
    output reg                     HOST_D7_OUT,
    output reg                     HOST_D7_OE,
    output reg                     HIGH_LATCH_EN_N,
    output reg                     LOW_LATCH_EN_N,
    output reg                     DMA_ACK_N,
    output reg                     DENSITY_SELECT_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers. Only the second stage is read by logic.

reg [4:0] sync1_q;
reg [4:0] sync2_q;

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        sync1_q <= 5'h1F;
        sync2_q <= 5'h1F;
    end else begin
        sync1_q <= {IOR_N, IOW_N, AEN, IOCS16_N, SHARED_PIN};
        sync2_q <= sync1_q;
    end
end

wire rd_active  = ~sync2_q[4];
wire wr_active  = ~sync2_q[3];
wire aen_s      = sync2_q[2];
wire iocs16_s   = ~sync2_q[1];
wire shared_s   = sync2_q[0];

////////////////////////////////////////////////////////////////////////////////
// Address decode. The chosen base decides which register block belongs to the drive.

wire [`IIG_ADDR_W-1:0] base     = USE_SECONDARY ? `IIG_SEC_BASE : `IIG_PRI_BASE;
wire [`IIG_ADDR_W-1:0] alt_addr = USE_SECONDARY ? `IIG_SEC_ALT_STATUS : `IIG_PRI_ALT_STATUS;
wire [`IIG_ADDR_W-1:0] shr_addr = USE_SECONDARY ? `IIG_SEC_FLOPPY_SHR : `IIG_PRI_FLOPPY_SHR;

wire hit_block  = ((ADDR & `IIG_BLOCK_MASK) == base);
wire hit_alt    = (ADDR == alt_addr);
wire hit_shared = (ADDR == shr_addr);
wire cycle      = (rd_active | wr_active) & ~aen_s & IDE_ENABLE;
wire drive_cyc  = cycle & (hit_block | hit_alt | hit_shared);
wire d7_cyc     = cycle & (hit_block | hit_alt);

////////////////////////////////////////////////////////////////////////////////
// Strap capture. The synchroniser stages hold their reset level for the first
// edges after release, so the strap is taken only once the second stage carries
// the real pin level. Taking it at the first edge would always read the reset
// value and lose a strap of zero.

reg [1:0] strap_cnt_q;
reg [1:0] strap_cnt_d;
reg       strap_q;
reg       strap_d;
reg       strap_taken_q;
reg       strap_taken_d;

always @* begin
    strap_cnt_d   = strap_cnt_q;
    strap_d       = strap_q;
    strap_taken_d = strap_taken_q;
    if (!strap_taken_q) begin
        if (strap_cnt_q == `IIG_STRAP_DELAY) begin
            strap_taken_d = 1'b1;
            // In acknowledge mode the pin carries no strap, so one is assumed.
            strap_d       = FUNC_DMA_SEL ? 1'b1 : shared_s;
        end else begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
    end
end

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        strap_cnt_q   <= 2'h0;
        strap_q       <= `IIG_STRAP_RESET;
        strap_taken_q <= 1'b0;
    end else begin
        strap_cnt_q   <= strap_cnt_d;
        strap_q       <= strap_d;
        strap_taken_q <= strap_taken_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Density polarity. Acknowledge mode forces active high whatever was strapped,
// and the latched strap comes back into force when the pin returns to strap use.

wire dens_active_high = FUNC_DMA_SEL | strap_q;

////////////////////////////////////////////////////////////////////////////////
// Next values of the outputs. Every output has an inactive default, so any
// cycle that is not addressed to the drive leaves enables off and bit 7 floating.

reg ide_d7_oe_d;
reg host_d7_oe_d;
reg high_en_n_d;
reg low_en_n_d;
reg dma_ack_n_d;
reg density_d;

always @* begin
    ide_d7_oe_d  = 1'b0;
    host_d7_oe_d = 1'b0;
    high_en_n_d  = 1'b1;
    low_en_n_d   = 1'b1;
    dma_ack_n_d  = 1'b1;
    density_d    = 1'b0;

    // Floppy-shared ports belong partly to the floppy side, so bit 7 stays off them.
    if (d7_cyc & ~hit_shared) begin
        if (wr_active) begin
            ide_d7_oe_d = 1'b1;
        end
        if (rd_active) begin
            host_d7_oe_d = 1'b1;
        end
    end

    // The floppy-shared ports still open the byte latches.
    if (drive_cyc) begin
        low_en_n_d = 1'b0;
        if (iocs16_s) begin
            high_en_n_d = 1'b0;
        end
    end
    if (!IDE_ENABLE) begin
        high_en_n_d = 1'b1;
    end

    // The pin is active low as an acknowledge and is passed on as it stands.
    if (FUNC_DMA_SEL) begin
        dma_ack_n_d = shared_s;
    end else begin
        dma_ack_n_d = 1'b1;
    end

    // Low rates leave density at its inactive level for the chosen polarity.
    if (HIGH_RATE) begin
        density_d = dens_active_high;
    end else begin
        density_d = ~dens_active_high;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bit 7 path. Data always follows its source; only the enables decide who
// drives, which keeps the data flip-flops free of decode logic.

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        IDE_D7_OUT  <= 1'b0;
        IDE_D7_OE   <= 1'b0;
        HOST_D7_OUT <= 1'b0;
        HOST_D7_OE  <= 1'b0;
    end else begin
        IDE_D7_OUT  <= HOST_D7_IN;
        IDE_D7_OE   <= ide_d7_oe_d;
        HOST_D7_OUT <= IDE_D7_IN;
        HOST_D7_OE  <= host_d7_oe_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Byte latch enables. They follow the strobe three edges late, so a host strobe
// shorter than one cycle may be missed altogether.

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        HIGH_LATCH_EN_N <= 1'b1;
        LOW_LATCH_EN_N  <= 1'b1;
    end else begin
        HIGH_LATCH_EN_N <= high_en_n_d;
        LOW_LATCH_EN_N  <= low_en_n_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Acknowledge and density outputs.

always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        DMA_ACK_N          <= 1'b1;
        DENSITY_SELECT_OUT <= 1'b0;
    end else begin
        DMA_ACK_N          <= dma_ack_n_d;
        DENSITY_SELECT_OUT <= density_d;
    end
end

endmodule

// *** rtl/iig_map.vh ***
// Constants for the IDE interface glue: host I/O addresses, control bit positions and reset values.
// Assumes a 10-bit host I/O address bus.
`ifndef IIG_MAP_VH
`define IIG_MAP_VH

`define IIG_ADDR_W          10
`define IIG_PRI_BASE        10'h1F0
`define IIG_SEC_BASE        10'h170
`define IIG_PRI_ALT_STATUS  10'h3F6
`define IIG_SEC_ALT_STATUS  10'h376
`define IIG_PRI_FLOPPY_SHR  10'h3F7
`define IIG_SEC_FLOPPY_SHR  10'h377
`define IIG_BLOCK_MASK      10'h3F8
`define IIG_FUNC_DMA_BIT    1
`define IIG_STRAP_RESET     1'h1
`define IIG_STRAP_DELAY     2'h2

`endif

// *** tb/iig_checker.sv ***
// Port-level checker for the IDE interface glue, bound to every instance.
// Assumes host strobes and pins may arrive at any time; outputs follow three edges later.
`timescale 1ns/100ps
module iig_checker(input wire CLK, ARST_N, input wire [9:0] ADDR, input wire IOR_N, IOW_N, AEN, IOCS16_N,
    SHARED_PIN, FUNC_DMA_SEL, IDE_ENABLE, USE_SECONDARY, HIGH_RATE, IDE_D7_OE, HIGH_LATCH_EN_N,
    LOW_LATCH_EN_N, DMA_ACK_N, DENSITY_SELECT_OUT);
    wire s = USE_SECONDARY;
    wire ok = IDE_ENABLE && !AEN;
    wire rg = ok && ((ADDR & 10'h3F8) == (s ? 10'h170 : 10'h1F0) || ADDR == (s ? 10'h376 : 10'h3F6));
    wire fl = ok && ADDR == (s ? 10'h377 : 10'h3F7);
    wire st = !(IOR_N && IOW_N);
    // Four stable samples cover the two sync stages and the output register.
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    lo_latch_a: assert property ((st && (rg || fl))[*4] |-> !LOW_LATCH_EN_N) else $error("low latch idle");
    hi_latch_a: assert property ((st && rg && !IOCS16_N)[*4] |-> !HIGH_LATCH_EN_N) else $error("high latch idle");
    hi_narrow_a: assert property (IOCS16_N[*4] |-> HIGH_LATCH_EN_N) else $error("high latch narrow");
    hi_off_a: assert property ((!IDE_ENABLE)[*4] |-> HIGH_LATCH_EN_N) else $error("high latch disabled");
    idle_out_a: assert property ((!st)[*4] |-> LOW_LATCH_EN_N && !IDE_D7_OE) else $error("idle outputs");
    d7_drive_a: assert property ((!IOW_N && rg)[*4] |-> IDE_D7_OE) else $error("bit 7 not driven");
    d7_float_a: assert property (fl[*4] |-> !IDE_D7_OE) else $error("bit 7 driven");
    ack_pass_a: assert property ((FUNC_DMA_SEL && $stable(SHARED_PIN))[*4] |-> DMA_ACK_N == SHARED_PIN)
        else $error("ack not passed");
    ack_off_a: assert property ((!FUNC_DMA_SEL)[*4] |-> DMA_ACK_N) else $error("ack in strap mode");
    dens_dma_a: assert property ((FUNC_DMA_SEL && HIGH_RATE)[*4] |-> DENSITY_SELECT_OUT) else $error("density");
endmodule
bind iig_glue iig_checker u_chk(.*);

// *** tb/iig_drive.sv ***
// Behavioural hard drive: 16-bit indication and read data bit 7.
// Assumes cs is the host strobe as seen at the drive.
`timescale 1ns/100ps
module iig_drive(input wire [9:0] ADDR, input wire cs, wide, output wire IOCS16_N, IDE_D7_IN);
    // A selected port at offset 0 is wide only while wide is set; bit 7 flips when deselected so no stale value lingers.
    assign IOCS16_N = !(cs && wide && ADDR[2:0] == 3'h0);
    assign IDE_D7_IN = cs ? !ADDR[0] : ADDR[0];
endmodule

// *** tb/iig_glue_tb_top.sv ***
// Self-checking bench for the IDE interface glue: random host cycles over corner addresses.
// Assumes the checker is bound and the drive model answers the 16-bit indication.
`timescale 1ns/100ps
module iig_glue_tb_top;
    logic clk = 0, arst_n = 0, ior_n = 1, iow_n = 1, aen = 0, hd = 0, pin = 0, dsel = 0, en = 1;
    logic sec = 0, hr = 0, wide = 0, wr, act, k, f;
    logic [9:0] addr = 10'h000;
    logic [9:0] at [8] = '{10'h1F0, 10'h1F7, 10'h3F6, 10'h3F7, 10'h170, 10'h376, 10'h377, 10'h2F8};
    wire io16_n, id7, lo, hi, ioe, ack, den, hoe, d7o, h7o;
    int num_errors = 0, tests_run = 0, p, i;
    always #5 clk = ~clk;
    iig_glue u_dut(.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .IOR_N(ior_n), .IOW_N(iow_n), .AEN(aen),
        .HOST_D7_IN(hd), .IDE_D7_IN(id7), .IOCS16_N(io16_n), .SHARED_PIN(pin), .FUNC_DMA_SEL(dsel),
        .IDE_ENABLE(en), .USE_SECONDARY(sec), .HIGH_RATE(hr), .IDE_D7_OUT(d7o), .IDE_D7_OE(ioe),
        .HOST_D7_OUT(h7o), .HOST_D7_OE(hoe), .HIGH_LATCH_EN_N(hi), .LOW_LATCH_EN_N(lo), .DMA_ACK_N(ack),
        .DENSITY_SELECT_OUT(den));
    iig_drive u_drv(.ADDR(addr), .cs(!(ior_n && iow_n)), .wide(wide), .IOCS16_N(io16_n), .IDE_D7_IN(id7));
    function bit r(); return 1'($urandom); endfunction
    task chk(string n, logic s, logic e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", n, e, s);
        end
    endtask
    task test_done();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin #50000; num_errors++; test_done(); end
    initial begin
        void'($urandom(32'h7C03));
        for (p = 0; p < 2; p++) begin
            pin <= p[0]; dsel <= 0; arst_n <= 0;
            repeat (4) @(posedge clk);
            arst_n <= 1;
            for (i = 0; i < 40; i++) begin
                repeat (4) @(posedge clk);
                addr <= at[i % 8]; sec <= r(); dsel <= r(); en <= i % 5 != 0; aen <= i % 7 == 3;
                wide <= r(); hr <= r(); pin <= r(); hd <= r(); wr = r();
                repeat (4) @(posedge clk);
                if (wr) iow_n <= 0; else ior_n <= 0;
                repeat (5) @(posedge clk);
                #1;
                f = addr == (sec ? 10'h377 : 10'h3F7);
                k = (addr & 10'h3F8) == (sec ? 10'h170 : 10'h1F0) || addr == (sec ? 10'h376 : 10'h3F6);
                act = en && !aen && (k || f);
                chk("low latch", lo, !act);
                chk("high latch", hi, !(act && k && wide && addr[2:0] == 3'h0));
                chk("bit 7 enable", ioe, wr && act && k);
                chk("host bit 7 enable", hoe, !wr && act && k);
                chk("bit 7 to drive", d7o, hd);
                chk("bit 7 to host", h7o, !addr[0]);
                chk("dma ack", ack, dsel ? pin : 1'b1);
                chk("density", den, hr ? (dsel | p[0]) : !(dsel | p[0]));
                ior_n <= 1; iow_n <= 1;
                repeat (4) @(posedge clk);
                #1 chk("idle", lo & hi & !ioe & !hoe, 1'b1);
            end
        end
        test_done();
    end
endmodule
